// file: rtl/dhp_host_port.sv
// Host parallel bus port of the display controller
// Behaviour
// - Without glyph ROM, glyph RAM start address must be zero.
// - Strobe pins are interpreted per the bus style strap bits.
// - Separate strobes: read, data/parameter write, command write decoded.
// - Enable style: enable high, direction and select choose the access.
// - Data strobe style: strobe low, direction and select choose access.
// - Parameter bytes update registers at once; new command skips the rest.
// - Cursor bytes apply singly; paired parameters apply together or drop.
`timescale 1ns/1ps
`default_nettype none
module dhp_host_port (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Host bus pins
    input wire logic [4:0] bus_config_straps,
    input wire logic chip_select,
    input wire logic command_data_select,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic lower_data_strobe_n,
    input wire logic address_strobe_in,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    // Controller side
    input wire logic [7:0] display_read_data,
    input wire logic use_glyph_rom,
    output logic [7:0] command,
    output logic command_strobe,
    output logic [7:0] param_data,
    output logic [3:0] param_index,
    output logic param_strobe,
    output logic [15:0] cursor_address,
    output logic [15:0] glyph_ram_addr,
    output logic [15:0] pair_param,
    output logic pair_strobe,
    output logic glyph_addr_error
);
    logic [2:0] style;
    logic [1:0] prev_access;
    logic [7:0] low_byte;
    logic low_held;
    logic is_pair_cmd;
    logic access_start;
    logic cursor_read;
    dhp_decode_if dec ();

    dhp_decoder u_decoder (
        .style(style),
        .chip_select(chip_select),
        .command_data_select(command_data_select),
        .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n),
        .lower_data_strobe_n(lower_data_strobe_n),
        .dec(dec)
    );

    // Straps caught while reset is held; later strap changes are not followed,
    // which keeps a glitching strap from flipping style mid-access.
    // strap style select
    always_ff @(posedge clk) begin
        if (!reset_n)
            style <= bus_config_straps[dhp_pkg::STYLE_MSB:dhp_pkg::STYLE_LSB];
    end

    // One action per access: act on the first cycle the access is decoded
    always_ff @(posedge clk) begin
        if (!reset_n)
            prev_access <= 2'(dhp_pkg::DHP_ACC_NONE);
        else
            prev_access <= dec.access;
    end
    assign access_start = (dec.access != dhp_pkg::DHP_ACC_NONE) &&
        (2'(dec.access) != prev_access);
    assign is_pair_cmd = (command == dhp_pkg::CMD_SYSTEM_SET) ||
        (command == dhp_pkg::CMD_SCROLL) ||
        (command == dhp_pkg::CMD_GLYPH_ADDR);
    assign cursor_read = (dec.access == dhp_pkg::DHP_ACC_READ) &&
        (command == dhp_pkg::CMD_CURSOR_READ);

    // Command capture and strobe
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            command <= dhp_pkg::CMD_RESET;
            command_strobe <= 1'b0;
        end else begin
            command_strobe <= 1'b0;
            if (access_start && dec.access == dhp_pkg::DHP_ACC_CWRITE) begin
                command <= data_in;
                command_strobe <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            param_data <= 8'h00;
            param_index <= dhp_pkg::PARAM_IDX_RESET;
            param_strobe <= 1'b0;
        end else begin
            param_strobe <= 1'b0;
            if (access_start && dec.access == dhp_pkg::DHP_ACC_CWRITE)
                param_index <= dhp_pkg::PARAM_IDX_RESET;
            else if (access_start &&
                     dec.access == dhp_pkg::DHP_ACC_DWRITE) begin
                param_data <= data_in;
                param_strobe <= 1'b1;
                param_index <= param_index + 4'h1;
            end else if (access_start && cursor_read) begin
                param_index <= param_index + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n)
            cursor_address <= dhp_pkg::CURSOR_RESET;
        else if (access_start && dec.access == dhp_pkg::DHP_ACC_DWRITE &&
                 command == dhp_pkg::CMD_CURSOR_WRITE) begin
            if (param_index == 4'h0)
                cursor_address[7:0] <= data_in;
            else if (param_index == 4'h1)
                cursor_address[15:8] <= data_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            low_byte <= 8'h00;
            low_held <= 1'b0;
            pair_param <= 16'h0000;
            pair_strobe <= 1'b0;
            glyph_ram_addr <= dhp_pkg::GLYPH_ADDR_RESET;
        end else begin
            pair_strobe <= 1'b0;
            // A lone first byte is dropped when a new command arrives
            if (access_start && dec.access == dhp_pkg::DHP_ACC_CWRITE)
                low_held <= 1'b0;
            else if (access_start && dec.access == dhp_pkg::DHP_ACC_DWRITE &&
                     is_pair_cmd) begin
                if (!low_held) begin
                    low_byte <= data_in;
                    low_held <= 1'b1;
                end else begin
                    low_held <= 1'b0;
                    pair_param <= {data_in, low_byte};
                    pair_strobe <= 1'b1;
                    if (command == dhp_pkg::CMD_GLYPH_ADDR)
                        glyph_ram_addr <= {data_in, low_byte};
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n)
            glyph_addr_error <= 1'b0;
        else
            glyph_addr_error <= !use_glyph_rom &&
                (glyph_ram_addr != dhp_pkg::GLYPH_ADDR_RESET);
    end

    // Read data: cursor bytes after the cursor read command, else memory
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            data_out <= 8'h00;
            data_oe_n <= 1'b1;
        end else begin
            data_oe_n <= !(dec.access == dhp_pkg::DHP_ACC_READ);
            // Latched once per access so the host sees a steady byte
            if (access_start && dec.access == dhp_pkg::DHP_ACC_READ) begin
                if (command == dhp_pkg::CMD_CURSOR_READ)
                    data_out <= param_index[0] ? cursor_address[15:8] :
                        cursor_address[7:0];
                else
                    data_out <= display_read_data;
            end
        end
    end

    property p_cursor_step;
        @(posedge clk) disable iff (!reset_n)
        (access_start && cursor_read) |=>
            param_index == $past(param_index) + 4'h1;
    endproperty
    a_cursor_step: assert property (p_cursor_step)
        else $error("cursor read did not step to next byte");

    logic unused_as;
    assign unused_as = address_strobe_in;

    property p_cmd_strobe;
        @(posedge clk) disable iff (!reset_n)
        (access_start && dec.access == dhp_pkg::DHP_ACC_CWRITE) |=>
            command_strobe && command == $past(data_in);
    endproperty
    a_cmd_strobe: assert property (p_cmd_strobe)
        else $error("command write not captured");

    property p_no_cs;
        @(posedge clk) disable iff (!reset_n)
        !chip_select |=> !command_strobe && !param_strobe;
    endproperty
    a_no_cs: assert property (p_no_cs)
        else $error("strobe acted without device select");

    property p_param;
        @(posedge clk) disable iff (!reset_n)
        (access_start && dec.access == dhp_pkg::DHP_ACC_DWRITE) |=>
            param_strobe && param_data == $past(data_in);
    endproperty
    a_param: assert property (p_param)
        else $error("parameter not updated at once");

    property p_pair_drop;
        @(posedge clk) disable iff (!reset_n)
        command_strobe |-> !pair_strobe ##1 !low_held;
    endproperty
    a_pair_drop: assert property (p_pair_drop)
        else $error("lone paired byte kept over new command");

    property p_read_oe;
        @(posedge clk) disable iff (!reset_n)
        (dec.access == dhp_pkg::DHP_ACC_READ) |=> !data_oe_n;
    endproperty
    a_read_oe: assert property (p_read_oe)
        else $error("read access did not drive data");

    property p_write_no_drive;
        @(posedge clk) disable iff (!reset_n)
        (dec.access == dhp_pkg::DHP_ACC_DWRITE) |=> data_oe_n;
    endproperty
    a_write_no_drive: assert property (p_write_no_drive)
        else $error("data driven during write");

    property p_glyph;
        @(posedge clk) disable iff (!reset_n)
        (!use_glyph_rom && glyph_ram_addr != 16'h0000) |=> glyph_addr_error;
    endproperty
    a_glyph: assert property (p_glyph)
        else $error("nonzero glyph base not flagged");

    property p_style_stable;
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> style == $past(style);
    endproperty
    a_style_stable: assert property (p_style_stable)
        else $error("bus style changed outside reset");
endmodule
`default_nettype wire

// file: rtl/dhp_pkg.sv
// Constants and types shared by the display host bus port
package dhp_pkg;
    // Bus style encodings on the three upper strap bits
    localparam logic [2:0] STYLE_SEPARATE = 3'h0;
    localparam logic [2:0] STYLE_ENABLE = 3'h1;
    localparam logic [2:0] STYLE_DATASTROBE = 3'h2;
    localparam int STYLE_LSB = 2;
    localparam int STYLE_MSB = 4;
    // Command codes; the first three carry paired two-byte parameters
    localparam logic [7:0] CMD_SYSTEM_SET = 8'h40;
    localparam logic [7:0] CMD_SCROLL = 8'h44;
    localparam logic [7:0] CMD_GLYPH_ADDR = 8'h5C;
    localparam logic [7:0] CMD_CURSOR_WRITE = 8'h46;
    localparam logic [7:0] CMD_CURSOR_READ = 8'h47;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [15:0] GLYPH_ADDR_RESET = 16'h0000;
    localparam logic [15:0] CURSOR_RESET = 16'h0000;
    localparam logic [3:0] PARAM_IDX_RESET = 4'h0;
    typedef enum logic [1:0] {
        DHP_ACC_NONE,
        DHP_ACC_READ,
        DHP_ACC_DWRITE,
        DHP_ACC_CWRITE
    } dhp_access_t;
endpackage

// file: rtl/dhp_decode_if.sv
// Decoded access carrier between decoder and port core
`timescale 1ns/1ps
`default_nettype none
interface dhp_decode_if;
    dhp_pkg::dhp_access_t access;
    modport decoder (output access);
    modport core (input access);
endinterface
`default_nettype wire

// file: rtl/dhp_decoder.sv
// Strobe decoder for the three host bus styles
`timescale 1ns/1ps
`default_nettype none
module dhp_decoder (
    // Straps and strobes
    input wire logic [2:0] style,
    input wire logic chip_select,
    input wire logic command_data_select,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic lower_data_strobe_n,
    // Decoded access
    dhp_decode_if.decoder dec
);
    always_comb begin
        dec.access = dhp_pkg::DHP_ACC_NONE;
        if (chip_select) begin
            case (style)
                dhp_pkg::STYLE_SEPARATE: begin
                    if (command_data_select && !read_strobe_n &&
                        write_strobe_n)
                        dec.access = dhp_pkg::DHP_ACC_READ;
                    else if (read_strobe_n && !write_strobe_n)
                        dec.access = command_data_select ?
                            dhp_pkg::DHP_ACC_CWRITE : dhp_pkg::DHP_ACC_DWRITE;
                end
                // enable with direction on write_strobe_n pin
                dhp_pkg::STYLE_ENABLE: begin
                    if (read_strobe_n) begin
                        if (command_data_select && write_strobe_n)
                            dec.access = dhp_pkg::DHP_ACC_READ;
                        else if (!write_strobe_n)
                            dec.access = command_data_select ?
                                dhp_pkg::DHP_ACC_CWRITE :
                                dhp_pkg::DHP_ACC_DWRITE;
                    end
                end
                dhp_pkg::STYLE_DATASTROBE: begin
                    if (!lower_data_strobe_n) begin
                        if (command_data_select && write_strobe_n)
                            dec.access = dhp_pkg::DHP_ACC_READ;
                        else if (!write_strobe_n)
                            dec.access = command_data_select ?
                                dhp_pkg::DHP_ACC_CWRITE :
                                dhp_pkg::DHP_ACC_DWRITE;
                    end
                end
                default: dec.access = dhp_pkg::DHP_ACC_NONE;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: sim/dhp_host_model.sv
// Host processor model driving the parallel bus pins
`timescale 1ns/1ps
`default_nettype none
module dhp_host_model (
    // Clock and bus style
    input wire logic clk,
    input wire logic [2:0] style,
    // Host bus pins
    output logic chip_select,
    output logic command_data_select,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic lower_data_strobe_n,
    output logic [7:0] data_in
);
    initial begin
        chip_select = 1'b0;
        command_data_select = 1'b0;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        lower_data_strobe_n = 1'b1;
        data_in = 8'h00;
    end

    task automatic park();
        chip_select <= 1'b0;
        read_strobe_n <= (style == dhp_pkg::STYLE_ENABLE) ? 1'b0 : 1'b1;
        write_strobe_n <= 1'b1;
        lower_data_strobe_n <= 1'b1;
        // Released bus shows inverted data, never a stale copy
        data_in <= ~data_in;
    endtask

    task automatic access(input logic sel, input logic cds, input logic rd,
                          input logic [7:0] d);
        @(posedge clk);
        chip_select <= sel;
        command_data_select <= cds;
        data_in <= rd ? ~data_in : d;
        write_strobe_n <= rd;
        case (style)
            dhp_pkg::STYLE_SEPARATE: read_strobe_n <= ~rd;
            dhp_pkg::STYLE_ENABLE: read_strobe_n <= 1'b1;
            default: lower_data_strobe_n <= 1'b0;
        endcase
        repeat (2) @(posedge clk);
        park();
        repeat (2) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: sim/dhp_host_port_tb_top.sv
// Self-checking bench for the host bus port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module dhp_host_port_tb_top;
    logic clk, reset_n, use_glyph_rom, oe_was;
    logic [4:0] straps;
    logic [7:0] display_read_data, data_out, command, param_data, b, a;
    logic [3:0] param_index;
    logic [15:0] cursor_address, glyph_ram_addr, pair_param;
    logic data_oe_n, command_strobe, param_strobe, pair_strobe, gerr;
    wire logic cs, cds, rs_n, ws_n, lds_n;
    wire logic [7:0] data_in;
    int err_total, checks, seed, st;
    logic [19:0] exp_q[$];

    always #25 clk = ~clk;

    dhp_host_model dhp_host_model_i (.clk(clk), .style(straps[4:2]),
        .chip_select(cs), .command_data_select(cds), .read_strobe_n(rs_n),
        .write_strobe_n(ws_n), .lower_data_strobe_n(lds_n),
        .data_in(data_in));

    dhp_host_port dhp_host_port_i (.clk(clk), .reset_n(reset_n),
        .bus_config_straps(straps), .chip_select(cs),
        .command_data_select(cds), .read_strobe_n(rs_n),
        .write_strobe_n(ws_n), .lower_data_strobe_n(lds_n),
        .address_strobe_in(1'b0), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .display_read_data(display_read_data),
        .use_glyph_rom(use_glyph_rom), .command(command),
        .command_strobe(command_strobe), .param_data(param_data),
        .param_index(param_index), .param_strobe(param_strobe),
        .cursor_address(cursor_address), .glyph_ram_addr(glyph_ram_addr),
        .pair_param(pair_param), .pair_strobe(pair_strobe),
        .glyph_addr_error(gerr));

    task automatic take(input logic [3:0] k, input logic [15:0] v);
        logic [19:0] e;
        e = 20'hFFFFF;
        if (exp_q.size() != 0) e = exp_q.pop_front();
        `CHK({k, v}, e)
    endtask

    always @(negedge clk) begin
        if (reset_n === 1'b1) begin
            if (command_strobe !== 1'b0) take(4'h1, {8'h00, command});
            if (param_strobe !== 1'b0) take(4'h2, {8'h0, param_data});
            if (pair_strobe !== 1'b0) take(4'h3, pair_param);
            if (data_oe_n === 1'b0 && oe_was === 1'b1)
                take(4'h4, {8'h00, data_out});
        end
        oe_was = data_oe_n;
    end

    task automatic cmd(input logic [7:0] c);
        exp_q.push_back({4'h1, 8'h00, c});
        dhp_host_model_i.access(1'b1, 1'b1, 1'b0, c);
    endtask

    task automatic par(input logic [7:0] d, input logic pr,
                       input logic [15:0] pv);
        exp_q.push_back({4'h2, 8'h00, d});
        if (pr) exp_q.push_back({4'h3, pv});
        dhp_host_model_i.access(1'b1, 1'b0, 1'b0, d);
    endtask

    task automatic rd(input logic [7:0] d);
        exp_q.push_back({4'h4, 8'h00, d});
        dhp_host_model_i.access(1'b1, 1'b1, 1'b1, 8'h00);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Waits until every noted result has been seen, within a bound
    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (exp_q.size() != 0) begin
            err_total++;
            $display("unexpected at %0t: results missing", $time);
            wrap_up();
        end
        // Let the last registered outputs settle before any check
        @(negedge clk);
    endtask

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        straps = 5'h00;
        use_glyph_rom = 1'b1;
        display_read_data = 8'h00;
        err_total = 0;
        checks = 0;
        seed = 31662;
        for (st = 0; st < 3; st++) begin
            @(posedge clk);
            reset_n <= 1'b0;
            straps <= {st[2:0], 2'h0};
            use_glyph_rom <= 1'b0;
            @(posedge clk);
            dhp_host_model_i.park();
            repeat (4) @(posedge clk);
            reset_n <= 1'b1;
            @(posedge clk);
            #1;
            `CHK({data_oe_n, cursor_address}, 17'h10000)
            // zero glyph base in each style
            cmd(dhp_pkg::CMD_GLYPH_ADDR);
            par(8'h00, 1'b0, 16'h0000);
            par(8'h00, 1'b1, 16'h0000);
            drain();
            `CHK({glyph_ram_addr, gerr}, 17'h00000)
            b = 8'($random(seed));
            cmd(dhp_pkg::CMD_CURSOR_WRITE);
            par(b, 1'b0, 16'h0000);
            cmd(8'h43);
            display_read_data <= 8'($random(seed));
            drain();
            `CHK(cursor_address, {8'h00, b})
            rd(display_read_data);
            dhp_host_model_i.access(1'b0, 1'b1, 1'b0, 8'h5C);
            // half scroll dropped, then full setup pair
            a = 8'($random(seed));
            cmd(dhp_pkg::CMD_SCROLL);
            par(a, 1'b0, 16'h0000);
            cmd(dhp_pkg::CMD_SYSTEM_SET);
            par(b, 1'b0, 16'h0000);
            par(a, 1'b1, {a, b});
            // cursor read low then high byte
            cmd(dhp_pkg::CMD_CURSOR_READ);
            rd(b);
            rd(8'h00);
            // nonzero glyph base without ROM is flagged
            cmd(dhp_pkg::CMD_GLYPH_ADDR);
            par(8'h01, 1'b0, 16'h0000);
            par(8'h00, 1'b1, 16'h0001);
            drain();
            `CHK({glyph_ram_addr, gerr, param_index}, 21'h000032)
            // glyph ROM in use clears flag
            @(posedge clk);
            use_glyph_rom <= 1'b1;
            repeat (2) @(posedge clk);
            @(negedge clk);
            `CHK(gerr, 1'b0)
            $display("test %0d done", st);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
